// >>> pkg/sbs_pkg.sv
// Shared constants, types and burst-order arithmetic for the sync burst SRAM core.
// Assumes it is compiled before every core file; nothing is imported, all uses are scoped.
package sbs_pkg;

  // Array geometry: 512K words of 72 bits, eight 9-bit byte lanes
  localparam int ADDR_W = 19;
  localparam int DATA_W = 72;
  localparam int LANES = 8;
  localparam int LANE_W = DATA_W / LANES;

  // Burst counter acts on the two low address bits only
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // Mode pin levels
  localparam logic ORDER_LINEAR = 1'h0;
  localparam logic ORDER_INTERLEAVED = 1'h1;
  localparam logic OUT_FLOW_THROUGH = 1'h0;
  localparam logic OUT_PIPELINED = 1'h1;
  localparam logic DESELECT_DUAL = 1'h0;
  localparam logic DESELECT_SINGLE = 1'h1;

  // Levels the mode pins settle to when left floating
  localparam logic DEFAULT_ORDER = ORDER_INTERLEAVED;
  localparam logic DEFAULT_OUT = OUT_PIPELINED;
  localparam logic DEFAULT_DESELECT = DESELECT_SINGLE;

  // Cycle kind seen at one clock edge
  typedef enum logic [1:0] {
    SBS_IDLE = 2'h0,
    SBS_LOAD = 2'h1,
    SBS_ADVANCE = 2'h2,
    SBS_SUSPEND = 2'h3
  } sbs_cycle_type;

  // Burst address for a given start and step count in the chosen order
  function automatic logic [BURST_W-1:0] sbs_burst_addr(
      input logic [BURST_W-1:0] start,
      input logic [BURST_W-1:0] count,
      input logic order_sel);
    logic [BURST_W-1:0] result;
    result = BURST_ZERO;
    if (order_sel == ORDER_LINEAR) begin
      result = start + count;
    end else begin
      result = start ^ count;
    end
    return result;
  endfunction

endpackage

// >>> core/sbs_burst_counter.sv
// Two-bit burst address counter with linear or interleaved order.
// Assumes load and advance come from the same clock domain and are never both high.
module sbs_burst_counter (
  input wire logic mclk,
  input wire logic reset,
  input wire logic load,
  input wire logic advance,
  input wire logic [sbs_pkg::BURST_W-1:0] start_bits,
  input wire logic order_sel,
  output logic [sbs_pkg::BURST_W-1:0] cur_bits,
  output logic [sbs_pkg::BURST_W-1:0] next_bits
);

  typedef struct packed {
    logic [sbs_pkg::BURST_W-1:0] start;
    logic [sbs_pkg::BURST_W-1:0] count;
    logic [sbs_pkg::BURST_W-1:0] cur;
  } sbs_cnt_state_type;

  sbs_cnt_state_type state_reg;
  sbs_cnt_state_type state_next;
  logic [sbs_pkg::BURST_W-1:0] count_inc;

  // Count wraps by width, so the start value returns on the fifth clock
  always_comb begin
    state_next = state_reg;
    count_inc = state_reg.count + sbs_pkg::BURST_STEP;
    next_bits = sbs_pkg::sbs_burst_addr(state_reg.start, count_inc, order_sel);
    if (load) begin
      state_next.start = start_bits;
      state_next.count = sbs_pkg::BURST_ZERO;
      state_next.cur = start_bits;
    end else if (advance) begin
      state_next.count = count_inc;
      state_next.cur = next_bits;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cur_bits = state_reg.cur;

endmodule

// >>> core/sbs_core.sv
// Control logic and storage of a 512K x 72 synchronous burst SRAM, device side.
// Assumes the host drives every synchronous input in step with mclk and ties the mode pins.
//
// Functional notes
// - Synchronous inputs captured on rising clock only
// - Output enable and sleep act without clock
// - Either address strobe loads the burst counter
// - Burst steps only when advance is asserted
// - Counter covers two low address bits
// - Linear or interleaved order from select pin
// - New address accepted every cycle, no penalty
// - Bypass select low gives flow-through reads
// - Bypass select high adds output register stage
// - Dual deselect pipelined like a read
// - Single deselect releases outputs one stage early
// - Dual deselect turns outputs off one edge later
// - Deselect mode pin picks single or dual, pipelined mode only
// - Partial write touches only selected byte lanes
// - Global write stores all lanes, ignores selects
// - Floating mode pins: single, interleaved, pipelined
// - Writes self-timed, no pulse width needed
// - Array of 512K words, 72 bits each
// - Linear adds, interleaved XORs; wraps on fifth
// - Order select low is linear, high interleaved
module sbs_core #(
  parameter int ADDR_W = sbs_pkg::ADDR_W,
  parameter int DATA_W = sbs_pkg::DATA_W,
  parameter int LANES = sbs_pkg::LANES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic chip_select_low_primary_n,
  input wire logic chip_select_high,
  input wire logic chip_select_low_secondary_n,
  input wire logic proc_addr_strobe_n,
  input wire logic cache_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic all_lanes_write_n,
  input wire logic partial_write_enable_n,
  input wire logic [LANES-1:0] lane_write_selects_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_select_n,
  input wire logic output_register_bypass_select_n,
  input wire logic deselect_mode_select,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe
);

  localparam int LANE_W = DATA_W / LANES;
  localparam int WORDS = 2 ** ADDR_W;
  localparam int BW = sbs_pkg::BURST_W;

  typedef struct packed {
    logic burst_active;
    logic [ADDR_W-1:0] base_addr;
    logic rd_stage;
    logic [DATA_W-1:0] stage_data;
    logic out_drive;
    logic [DATA_W-1:0] out_data;
  } sbs_core_state_type;

  sbs_core_state_type state_reg;
  sbs_core_state_type state_next;

  // One word per address, written lane by lane
  logic [DATA_W-1:0] mem [WORDS];

  logic selected;
  logic strobe;
  logic load;
  logic deselect;
  logic advance;
  logic suspend;
  logic active;
  logic order_sel;
  logic pipelined;
  logic dual_deselect;
  logic write_all;
  logic is_write;
  logic is_read;
  logic [LANES-1:0] lane_mask;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] rd_word;
  logic [BW-1:0] cur_bits;
  logic [BW-1:0] next_bits;
  logic [BW-1:0] acc_bits;
  sbs_pkg::sbs_cycle_type cycle_kind;

  // Mode pins are static levels, read straight; tie them to the floating defaults if unused
  assign order_sel = burst_order_select_n;
  assign pipelined = (output_register_bypass_select_n == sbs_pkg::OUT_PIPELINED);
  assign dual_deselect = (deselect_mode_select == sbs_pkg::DESELECT_DUAL);

  // Chip select decode, only meaningful alongside a strobe
  assign selected = ~chip_select_low_primary_n & chip_select_high
                    & ~chip_select_low_secondary_n;

  // Sleep gates command decode without waiting for an edge
  assign strobe = (~proc_addr_strobe_n | ~cache_addr_strobe_n) & ~sleep_request;
  assign load = strobe & selected;
  assign deselect = strobe & ~selected;
  assign advance = ~strobe & ~sleep_request & state_reg.burst_active
                   & ~burst_advance_n;
  assign suspend = ~strobe & ~sleep_request & state_reg.burst_active & burst_advance_n;
  assign active = load | advance | suspend;

  // Cycle classification, used for readability of the address mux
  always_comb begin
    cycle_kind = sbs_pkg::SBS_IDLE;
    if (load) begin
      cycle_kind = sbs_pkg::SBS_LOAD;
    end else if (advance) begin
      cycle_kind = sbs_pkg::SBS_ADVANCE;
    end else if (suspend) begin
      cycle_kind = sbs_pkg::SBS_SUSPEND;
    end
  end

  // Burst counter on the two low address bits
  sbs_burst_counter u_counter (
    .mclk(mclk),
    .reset(reset),
    .load(load),
    .advance(advance),
    .start_bits(addr_in[BW-1:0]),
    .order_sel(order_sel),
    .cur_bits(cur_bits),
    .next_bits(next_bits)
  );

  // Access address for this edge; a fresh load bypasses the counter so no cycle is lost
  always_comb begin
    acc_bits = cur_bits;
    acc_addr = state_reg.base_addr;
    unique case (cycle_kind)
      sbs_pkg::SBS_LOAD: begin
        acc_addr = addr_in;
        acc_bits = addr_in[BW-1:0];
      end
      sbs_pkg::SBS_ADVANCE: begin
        acc_bits = next_bits;
      end
      sbs_pkg::SBS_SUSPEND: begin
        acc_bits = cur_bits;
      end
      sbs_pkg::SBS_IDLE: begin
        acc_bits = cur_bits;
      end
    endcase
    acc_addr[BW-1:0] = acc_bits;
  end

  // Write decode: global write overrides the lane controls entirely
  assign write_all = ~all_lanes_write_n;
  always_comb begin
    lane_mask = '0;
    if (write_all) begin
      lane_mask = '1;
    end else if (~partial_write_enable_n) begin
      lane_mask = ~lane_write_selects_n;
    end
  end
  // A byte write with no lanes chosen is still a write cycle and reads nothing
  assign is_write = active & (write_all | ~partial_write_enable_n);
  assign is_read = active & ~is_write;

  // Writes finish inside the capturing edge, so no external pulse timing exists
  always_ff @(posedge mclk) begin
    for (int i = 0; i < LANES; i++) begin
      if (is_write && lane_mask[i]) begin
        mem[acc_addr][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
      end
    end
  end

  assign rd_word = mem[acc_addr];

  // Next state: address hold, read pipeline and output drive
  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.burst_active = 1'h1;
      state_next.base_addr = addr_in;
    end else if (deselect) begin
      state_next.burst_active = 1'h0;
    end
    if (!sleep_request) begin
      state_next.rd_stage = is_read;
      state_next.stage_data = rd_word;
    end
    if (!pipelined) begin
      // Flow-through: array word goes out right after the capturing edge
      state_next.out_drive = is_read;
      if (is_read) begin
        state_next.out_data = rd_word;
      end
    end else begin
      // Pipelined: one more register between array and pins
      if (state_reg.rd_stage) begin
        state_next.out_data = state_reg.stage_data;
      end
      if (dual_deselect) begin
        state_next.out_drive = state_reg.rd_stage;
      end else begin
        // Single deselect cuts drive at the very edge it is captured
        state_next.out_drive = state_reg.rd_stage & ~deselect;
      end
    end
  end

  // Core control state in one register, cleared by the synchronous reset; the burst counter keeps its own
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign data_out = state_reg.out_data;
  // Output enable must act at once, so it gates the registered drive without a clock
  assign data_oe = state_reg.out_drive & ~output_enable_n;

  default clocking sbs_cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_pipe_read;
    pipelined && is_read && !sleep_request;
  endsequence

  sequence s_dual_desel;
    pipelined && dual_deselect && state_reg.rd_stage && deselect;
  endsequence

  a_strobe_load: assert property (load |=> cur_bits == $past(addr_in[BW-1:0]))
    else $error("burst counter did not load strobe address");

  a_hold_no_advance: assert property (suspend && !load |=> cur_bits == $past(cur_bits))
    else $error("burst counter moved without advance");

  a_linear_step: assert property (advance && order_sel == sbs_pkg::ORDER_LINEAR
      |=> cur_bits == 2'(($past(cur_bits) + 2'h1)))
    else $error("linear burst step wrong");

  a_interleave_start: assert property (load && order_sel == sbs_pkg::ORDER_INTERLEAVED
      ##1 advance [*3] ##1 advance |=> cur_bits == $past(addr_in[BW-1:0], 5))
    else $error("interleaved burst did not wrap on fifth clock");

  a_flow_latency: assert property (!pipelined && is_read
      |=> state_reg.out_drive && data_out == $past(rd_word))
    else $error("flow-through read not presented after capture edge");

  a_pipe_latency: assert property (s_pipe_read ##1 pipelined && !deselect
      |=> state_reg.out_drive && data_out == $past(rd_word, 2))
    else $error("pipelined read latency wrong");

  a_single_desel_off: assert property (pipelined && !dual_deselect && deselect
      |=> !state_reg.out_drive)
    else $error("single cycle deselect left outputs driven");

  a_dual_desel_hold: assert property (s_dual_desel |=> state_reg.out_drive)
    else $error("dual cycle deselect released outputs too early");

  a_dual_desel_off: assert property (s_dual_desel ##1 pipelined && dual_deselect
      |=> !state_reg.out_drive)
    else $error("dual cycle deselect kept outputs driven too long");

  a_global_write: assert property (is_write && write_all
      |=> mem[$past(acc_addr)] == $past(data_in))
    else $error("global write did not store all lanes");

  a_oe_release: assert property (output_enable_n |-> !data_oe)
    else $error("data driven while output enable is off");

  a_sleep_ignore: assert property (sleep_request |-> !active && !load)
    else $error("command taken during sleep");

endmodule

// >>> dv/sbs_host_model.sv
// Host controller model driving the synchronous pins of the SRAM core.
// Assumes the bench calls cyc once per clock; pins change 1 ns after each edge.
module sbs_host_model (
  input wire logic mclk,
  output logic [sbs_pkg::ADDR_W-1:0] addr_in,
  output logic [sbs_pkg::DATA_W-1:0] data_in,
  output logic chip_select_low_primary_n,
  output logic chip_select_high,
  output logic chip_select_low_secondary_n,
  output logic proc_addr_strobe_n,
  output logic cache_addr_strobe_n,
  output logic burst_advance_n,
  output logic all_lanes_write_n,
  output logic partial_write_enable_n,
  output logic [7:0] lane_write_selects_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] bad = 2'h0;

  // Kind k: 0 no strobe, 1 proc strobe, 2 cache strobe, 3 deselect
  task automatic set(input int k, input logic [18:0] a, input logic [71:0] d,
      input logic gw, input logic bw, input logic [7:0] ln, input logic burst_advance);
    addr_in = a;
    data_in = d;
    proc_addr_strobe_n = !(k == 1 || k == 3);
    cache_addr_strobe_n = (k != 2);
    burst_advance_n = burst_advance;
    {all_lanes_write_n, partial_write_enable_n, lane_write_selects_n} = {gw, bw, ln};
    // A deselect rotates through three invalid select patterns, each breaking one chip select
    {chip_select_low_primary_n, chip_select_high, chip_select_low_secondary_n} =
        (k != 3) ? 3'h2 : (bad == 2'h0) ? 3'h6 : (bad == 2'h1) ? 3'h0 : 3'h3;
    if (k == 3) bad = bad + 2'h1;
  endtask

  task automatic cyc(input int k, input logic [18:0] a, input logic [71:0] d,
      input logic gw, input logic bw, input logic [7:0] ln, input logic burst_advance);
    @(posedge mclk);
    #1;
    set(k, a, d, gw, bw, ln, burst_advance);
  endtask

  // Idle pins from time zero
  initial set(0, 19'h0, 72'h0, 1'h1, 1'h1, 8'hFF, 1'h1);
endmodule

// >>> dv/sbs_core_tb.sv
// Self-checking bench for the SRAM core with a shadow memory and a read queue.
// Assumes the host model drives the synchronous pins; the bench owns async and mode pins.
module sbs_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'h0, reset, output_enable_n, sleep_request;
  logic burst_order_select_n, output_register_bypass_select_n, deselect_mode_select;
  logic [18:0] addr_in, base, b;
  logic [71:0] data_in, data_out;
  logic chip_select_low_primary_n, chip_select_high, chip_select_low_secondary_n;
  logic proc_addr_strobe_n, cache_addr_strobe_n, burst_advance_n;
  logic all_lanes_write_n, partial_write_enable_n, data_oe;
  logic [7:0] lane_write_selects_n;
  logic [15:0] lfsr = 16'h5954;
  logic [71:0] mem [int];
  logic [71:0] exp_q [$];
  int due_q [$];
  logic [1:0] cnt;
  logic act, last_rd;
  // Async pins change together with the host pins, so no earlier command is caught by them
  logic sleep_nxt = 1'h0, oe_n_nxt = 1'h0;
  int fail_count = 0, check_count = 0, cyc_cnt = 0;

  sbs_host_model u_sbs_host_model (.mclk, .addr_in, .data_in, .chip_select_low_primary_n,
    .chip_select_high, .chip_select_low_secondary_n, .proc_addr_strobe_n,
    .cache_addr_strobe_n, .burst_advance_n, .all_lanes_write_n, .partial_write_enable_n,
    .lane_write_selects_n);
  sbs_core u_sbs_core (.mclk, .reset, .addr_in, .data_in, .chip_select_low_primary_n,
    .chip_select_high, .chip_select_low_secondary_n, .proc_addr_strobe_n,
    .cache_addr_strobe_n, .burst_advance_n, .all_lanes_write_n, .partial_write_enable_n,
    .lane_write_selects_n, .output_enable_n, .sleep_request, .burst_order_select_n,
    .output_register_bypass_select_n, .deselect_mode_select, .data_out, .data_oe);

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [71:0] rd72();
    logic [79:0] t;
    t = {rnd(), rnd(), rnd(), rnd(), rnd()};
    return t[71:0];
  endfunction
  function automatic logic [18:0] ra();
    logic [31:0] t;
    t = {rnd(), rnd()};
    return t[18:0];
  endfunction
  function automatic logic [7:0] r8();
    logic [15:0] t;
    t = rnd();
    return t[7:0];
  endfunction

  task automatic check(input string n, input logic [71:0] seen, input logic [71:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One host cycle; the shadow state mirrors what the core must do with it
  task automatic step(input int k, input logic [18:0] a, input logic gw, input logic bw,
      input logic [7:0] ln, input logic burst_advance);
    logic [71:0] d;
    logic [18:0] ea;
    d = rd72();
    u_sbs_host_model.cyc(k, a, d, gw, bw, ln, burst_advance);
    sleep_request = sleep_nxt;
    output_enable_n = oe_n_nxt;
    if (sleep_request) return;
    if (k == 3) begin
      // Single deselect cuts the read still waiting in the output register
      if (last_rd && output_register_bypass_select_n && deselect_mode_select) begin
        void'(exp_q.pop_back());
        void'(due_q.pop_back());
      end
      act = 1'h0;
      last_rd = 1'h0;
      return;
    end
    if (k != 0) begin
      base = a;
      cnt = 2'h0;
      act = 1'h1;
    end else if (!act) begin
      last_rd = 1'h0;
      return;
    end else if (!burst_advance) cnt++;
    ea = {base[18:2], burst_order_select_n ? base[1:0] ^ cnt : base[1:0] + cnt};
    last_rd = gw && bw && !output_enable_n;
    if (!gw) mem[ea] = d;
    else if (!bw) begin
      for (int i = 0; i < 8; i++) if (!ln[i]) mem[ea][9*i +: 9] = d[9*i +: 9];
    end else if (last_rd) begin
      exp_q.push_back(mem[ea]);
      due_q.push_back(cyc_cnt + 1 + int'(output_register_bypass_select_n));
    end
  endtask

  task automatic desel();
    step(3, ra(), 1'h1, 1'h1, 8'hFF, 1'h1);
  endtask

  // Cycle count with a ceiling against hangs
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  // Each driven cycle must carry the oldest pending read on its due cycle
  always @(negedge mclk) begin
    if (data_oe === 1'b1) begin
      if (exp_q.size() == 0) check("data_oe", 72'(data_oe), 72'h0);
      else begin
        check("data_out", data_out, exp_q.pop_front());
        check("latency", 72'(cyc_cnt), 72'(due_q.pop_front()));
      end
    end
  end

  // All eight mode combinations, the floating-pin defaults first
  initial begin
    {reset, output_enable_n, sleep_request} = 3'h4;
    for (int m = 7; m >= 0; m--) begin
      {burst_order_select_n, output_register_bypass_select_n, deselect_mode_select} = 3'(m);
      reset = 1'h1;
      repeat (8) @(posedge mclk);
      #1 reset = 1'h0;
      {act, last_rd} = 2'h0;
      b = ra();
      step(2, b, 1'h0, ^r8(), r8(), 1'h1);
      repeat (3) step(0, ra(), 1'h0, 1'h1, r8(), 1'h0);
      desel();
      step(2, b, 1'h1, 1'h0, r8(), 1'h1);
      desel();
      sleep_nxt = 1'h1;
      step(2, b, 1'h0, 1'h1, 8'hFF, 1'h1);
      step(0, ra(), 1'h1, 1'h1, 8'hFF, 1'h1);
      sleep_nxt = 1'h0;
      step(1, b, 1'h1, 1'h1, r8(), 1'h1);
      for (int i = 0; i < 5; i++) step(0, ra(), 1'h1, 1'h1, r8(), i == 4);
      desel();
      for (int i = 0; i < 4; i++) step(1 + i % 2, {b[18:2], 2'(3 - i)}, 1'h1, 1'h1, r8(), ^r8());
      desel();
      desel();
      oe_n_nxt = 1'h1;
      step(1, b, 1'h1, 1'h1, 8'hFF, 1'h1);
      desel();
      repeat (2) step(0, ra(), 1'h1, 1'h1, 8'hFF, 1'h1);
      oe_n_nxt = 1'h0;
      output_enable_n = 1'h0;
      check("pending", 72'(exp_q.size()), 72'h0);
    end
    give_verdict();
  end
endmodule
